/* File: design/apbx_defines.svh */
// Constants of the peripheral bus bridge: field positions and reset values
`ifndef APBX_DEFINES_SVH
`define APBX_DEFINES_SVH

// ****************************************
// Address decode
// ****************************************
// Lowest address bit of the peripheral index field
`define APBX_SEL_LSB 12

// ****************************************
// Reset values
// ****************************************
`define APBX_PADDR_RST 32'h0000_0000
`define APBX_PWDATA_RST 32'h0000_0000
`define APBX_PRDATA_RST 32'h0000_0000
`define APBX_PSEL_RST 32'h0000_0000

`endif

/* File: design/apbx_pkg.sv */
// Types used by the transfer sequencer of the peripheral bus bridge
`default_nettype none
package apbx_pkg;

    // ****************************************
    // Transfer state of the peripheral bus
    // ****************************************
    typedef enum logic [1:0] {
        APBX_IDLE   = 2'b00,
        APBX_SETUP  = 2'b01,
        APBX_ENABLE = 2'b10
    } apbx_state_e;

endpackage
`default_nettype wire

/* File: design/apbx_decode.sv */
// Address decoder turning an address into a one-hot peripheral select
`timescale 1ns/1ps
`default_nettype none
`include "apbx_defines.svh"

module apbx_decode #(
    parameter int ADDR_W = 32,
    parameter int NSEL   = 4
) (
    // Address in
    input  wire logic [ADDR_W-1:0] addr,
    // One-hot select out
    output logic      [NSEL-1:0]   sel
);

    localparam int IDX_W = (NSEL > 1) ? $clog2(NSEL) : 1;

    logic [IDX_W-1:0] idx;

    assign idx = addr[`APBX_SEL_LSB +: IDX_W];

    // ****************************************
    // Decode
    // ****************************************
    // Index values past NSEL select nothing, so at most one line is ever set
    always_comb begin
        sel = '0;
        for (int i = 0; i < NSEL; i++) begin
            sel[i] = (idx == IDX_W'(i));
        end
    end

endmodule
`default_nettype wire

/* File: design/apbx_rsp.sv */
// Answer register toward the system side: done pulse and captured read data
`timescale 1ns/1ps
`default_nettype none
`include "apbx_defines.svh"

module apbx_rsp #(
    parameter int DATA_W = 32
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              arst_n,
    // Transfer end from the sequencer, read data from the peripheral bus
    input  wire logic              done,
    input  wire logic              rd,
    input  wire logic [DATA_W-1:0] prdata,
    // Answer out
    output logic                   rsp_valid,
    output logic      [DATA_W-1:0] rsp_rdata
);

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] rdata;
    } apbx_rsp_s;

    apbx_rsp_s cur;
    apbx_rsp_s next_cur;

    // ****************************************
    // Capture
    // ****************************************
    // Registering the read data costs one cycle but keeps the path short
    always_comb begin
        next_cur       = cur;
        next_cur.valid = done;
        if (done && rd) begin
            next_cur.rdata = prdata;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cur.valid <= 1'b0;
            cur.rdata <= DATA_W'(`APBX_PRDATA_RST);
        end else begin
            cur <= next_cur;
        end
    end

    assign rsp_valid = cur.valid;
    assign rsp_rdata = cur.rdata;

endmodule
`default_nettype wire

/* File: design/apbx_bridge.sv */
// Peripheral bus bridge: transfer sequencer, select decode and answer path
`timescale 1ns/1ps
`default_nettype none
`include "apbx_defines.svh"

module apbx_bridge #(
    parameter int ADDR_W = 32,
    parameter int DATA_W = 32,
    parameter int NSEL   = 4
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              arst_n,
    // System-side request
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    // System-side answer
    output logic                   rsp_valid,
    output logic      [DATA_W-1:0] rsp_rdata,
    // Peripheral bus
    output logic      [ADDR_W-1:0] paddr,
    output logic                   pwrite,
    output logic      [DATA_W-1:0] pwdata,
    output logic      [NSEL-1:0]   psel,
    output logic                   penable,
    input  wire logic [DATA_W-1:0] prdata
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        apbx_pkg::apbx_state_e state;
        logic [ADDR_W-1:0]     paddr;
        logic                  pwrite;
        logic [DATA_W-1:0]     pwdata;
        logic [NSEL-1:0]       psel;
        logic                  penable;
    } apbx_mst_s;

    apbx_mst_s         cur;
    apbx_mst_s         next_cur;
    logic [NSEL-1:0]   dec_sel;
    logic              take;
    logic              done;

    // ****************************************
    // Address decode
    // ****************************************
    // latch and decode
    apbx_decode #(
        .ADDR_W (ADDR_W),
        .NSEL   (NSEL)
    ) u_decode (
        .addr (req_addr),
        .sel  (dec_sel)
    );

    // ****************************************
    // System-side handshake
    // ****************************************
    // slave toward system
    // A request is only taken where a new SETUP may follow, so no second
    // address register is needed; the requester simply waits during SETUP.
    assign req_ready = (cur.state == apbx_pkg::APBX_IDLE)
                    || (cur.state == apbx_pkg::APBX_ENABLE);
    assign take = req_valid && req_ready;

    assign done = (cur.state == apbx_pkg::APBX_ENABLE);

    // ****************************************
    // Transfer sequencer
    // ****************************************
    always_comb begin
        next_cur = cur;
        unique case (cur.state)
            apbx_pkg::APBX_IDLE: begin
                next_cur.psel    = '0;
                next_cur.penable = 1'b0;
                if (take) begin
                    next_cur.state = apbx_pkg::APBX_SETUP;
                end
            end
            apbx_pkg::APBX_SETUP: begin
                next_cur.state   = apbx_pkg::APBX_ENABLE;
                next_cur.penable = 1'b1;
            end
            apbx_pkg::APBX_ENABLE: begin
                next_cur.penable = 1'b0;
                if (take) begin
                    next_cur.state = apbx_pkg::APBX_SETUP;
                end else begin
                    next_cur.state = apbx_pkg::APBX_IDLE;
                    next_cur.psel  = '0;
                end
            end
            default: begin
                next_cur.state   = apbx_pkg::APBX_IDLE;
                next_cur.psel    = '0;
                next_cur.penable = 1'b0;
            end
        endcase
        if (take) begin
            next_cur.paddr  = req_addr;
            next_cur.pwrite = req_write;
            next_cur.psel   = dec_sel;
            if (req_write) begin
                next_cur.pwdata = req_wdata;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cur.state   <= apbx_pkg::APBX_IDLE;
            cur.paddr   <= ADDR_W'(`APBX_PADDR_RST);
            cur.pwrite  <= 1'b0;
            cur.pwdata  <= DATA_W'(`APBX_PWDATA_RST);
            cur.psel    <= NSEL'(`APBX_PSEL_RST);
            cur.penable <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    // ****************************************
    // Bus outputs
    // ****************************************
    // strobe straight from a flop
    assign paddr   = cur.paddr;
    assign pwrite  = cur.pwrite;
    assign pwdata  = cur.pwdata;
    assign psel    = cur.psel;
    assign penable = cur.penable;

    // ****************************************
    // Answer path
    // ****************************************
    // capture at end of enable
    apbx_rsp #(
        .DATA_W (DATA_W)
    ) u_rsp (
        .clock     (clock),
        .arst_n    (arst_n),
        .done      (done),
        .rd        (!cur.pwrite),
        .prdata    (prdata),
        .rsp_valid (rsp_valid),
        .rsp_rdata (rsp_rdata)
    );

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    a_idle_quiet: assert property (
        cur.state == apbx_pkg::APBX_IDLE |-> (psel == '0) && !penable
    ) else $error("select or strobe active while idle");

    a_setup_select: assert property (
        take |=> (cur.state == apbx_pkg::APBX_SETUP)
                 && (psel == $past(dec_sel)) && !penable
    ) else $error("setup did not select the decoded peripheral");

    a_setup_length: assert property (
        cur.state == apbx_pkg::APBX_SETUP |=> cur.state == apbx_pkg::APBX_ENABLE
    ) else $error("setup lasted other than one cycle");

    a_enable_strobe: assert property (
        cur.state == apbx_pkg::APBX_ENABLE |-> penable && (psel == $past(psel))
    ) else $error("enable without strobe or with changed select");

    a_setup_hold: assert property (
        cur.state == apbx_pkg::APBX_SETUP |=>
            $stable(paddr) && $stable(pwrite) && $stable(psel) && $stable(pwdata)
    ) else $error("bus outputs moved from setup into enable");

    a_enable_end: assert property (
        (cur.state == apbx_pkg::APBX_ENABLE) && !req_valid
            |=> !penable && (psel == '0) && (cur.state == apbx_pkg::APBX_IDLE)
    ) else $error("enable not followed by idle with nothing pending");

    a_back_to_back: assert property (
        (cur.state == apbx_pkg::APBX_ENABLE) && req_valid
            |=> (cur.state == apbx_pkg::APBX_SETUP) && !penable
    ) else $error("pending transfer did not go straight to setup");

    a_one_select: assert property (
        $onehot0(psel)
    ) else $error("more than one peripheral select active");

    a_idle_hold: assert property (
        ((cur.state == apbx_pkg::APBX_IDLE) && !req_valid) [*2]
            |-> $stable(paddr) && $stable(pwrite)
    ) else $error("address or direction moved between transfers");

    a_read_capture: assert property (
        (cur.state == apbx_pkg::APBX_ENABLE) && !pwrite
            |=> rsp_valid && (rsp_rdata == $past(prdata))
    ) else $error("read data not captured at end of enable");

    a_write_data: assert property (
        take && req_write |=> pwrite && (pwdata == $past(req_wdata))
                              && (paddr == $past(req_addr))
    ) else $error("write address or data not driven on the bus");

    a_answer_once: assert property (
        rsp_valid |-> $past(done) && !done
    ) else $error("answer pulse not tied to the end of enable");

    a_strobe_pulse: assert property (
        penable |=> !penable
    ) else $error("strobe stood longer than one cycle");

    a_strobe_source: assert property (
        penable |-> $past(cur.state == apbx_pkg::APBX_SETUP)
    ) else $error("strobe raised without a setup cycle before it");

    a_setup_wait: assert property (
        cur.state == apbx_pkg::APBX_SETUP |-> !req_ready
    ) else $error("request accepted in the middle of setup");

    a_same_select: assert property (
        done && take && (dec_sel == psel) |=> $stable(psel)
    ) else $error("select dropped between transfers to one peripheral");

    a_rdata_hold: assert property (
        !(done && !pwrite) |=> $stable(rsp_rdata)
    ) else $error("read answer changed without a finished read");

    a_read_keeps_wdata: assert property (
        take && !req_write |=> $stable(pwdata)
    ) else $error("write data moved on a read transfer");

    c_write: cover property (
        take && req_write ##2 done ##1 (cur.state == apbx_pkg::APBX_IDLE)
    );

    c_read: cover property (
        take && !req_write ##2 done ##1 rsp_valid
    );

    c_same_slave: cover property (
        done && take && (dec_sel == psel) ##1 (psel == $past(psel))
    );

    c_other_slave: cover property (
        done && take && (dec_sel != psel) && (dec_sel != '0)
    );

endmodule
`default_nettype wire

/* File: sim/apbx_slave_model.sv */
// Behavioural bank of peripheral slaves answering on the bridge's peripheral bus
`timescale 1ns/1ps
`default_nettype none

module apbx_slave_model #(
    parameter int NSEL = 4
) (
    // Clock and reset
    input  wire logic            clock,
    input  wire logic            arst_n,
    // Peripheral bus
    input  wire logic [31:0]     paddr,
    input  wire logic            pwrite,
    input  wire logic [31:0]     pwdata,
    input  wire logic [NSEL-1:0] psel,
    input  wire logic            penable,
    output logic      [31:0]     prdata
);
    logic [31:0] mem [NSEL*4];
    logic [31:0] last;
    logic        rd_on;
    int          idx;

    always_comb begin
        idx = 0;
        for (int i = 0; i < NSEL; i++) begin
            if (psel[i]) begin
                idx = i * 4 + int'(paddr[3:2]);
            end
        end
    end

    // drive only in a selected read ENABLE
    assign rd_on = (|psel) && penable && !pwrite;
    // Released bus flips every cycle so a stale word never passes for good data
    assign prdata = rd_on ? mem[idx] : ~last;

    // latch write data only in ENABLE at the rising edge; last takes prdata every cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            last <= 32'h0000_0000;
            for (int i = 0; i < NSEL * 4; i++) begin
                mem[i] <= 32'h0000_0000;
            end
        end else begin
            last <= prdata;
            if ((|psel) && penable && pwrite) begin
                mem[idx] <= pwdata;
            end
        end
    end
endmodule
`default_nettype wire

/* File: sim/apb_transfer_master_slave_tb_top.sv */
// Self-checking testbench of the peripheral bus bridge
`timescale 1ns/1ps
`default_nettype none
`include "apbx_defines.svh"

module apb_transfer_master_slave_tb_top;
    localparam int NSEL = 4;
    logic            clock     = 1'b0;
    logic            arst_n    = 1'b0;
    logic            req_valid = 1'b0;
    logic            req_write = 1'b0;
    logic [31:0]     req_addr  = 32'h0000_0000;
    logic [31:0]     req_wdata = 32'h0000_0000;
    logic            req_ready;
    logic            rsp_valid;
    logic [31:0]     rsp_rdata;
    logic [31:0]     paddr;
    logic            pwrite;
    logic [31:0]     pwdata;
    logic [NSEL-1:0] psel;
    logic            penable;
    logic [31:0]     prdata;
    logic            nxt_valid = 1'b0;
    logic            nxt_w;
    logic [31:0]     nxt_a;
    logic [31:0]     nxt_d;
    int              n_errors  = 0;
    int              checks    = 0;

    always #50 clock = ~clock;

    apbx_bridge #(.ADDR_W(32), .DATA_W(32), .NSEL(NSEL)) dut (
        .clock(clock), .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .paddr(paddr), .pwrite(pwrite),
        .pwdata(pwdata), .psel(psel), .penable(penable), .prdata(prdata)
    );

    apbx_slave_model #(.NSEL(NSEL)) slaves (
        .clock(clock), .arst_n(arst_n), .paddr(paddr), .pwrite(pwrite),
        .pwdata(pwdata), .psel(psel), .penable(penable), .prdata(prdata)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic stop_test();
        if (n_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] sel_of(input logic [31:0] a);
        return 32'(NSEL'(1) << a[`APBX_SEL_LSB +: 2]);
    endfunction

    task automatic put(input logic w, input logic [31:0] a, input logic [31:0] d);
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
    endtask

    task automatic set_next(input logic w, input logic [31:0] a, input logic [31:0] d);
        nxt_valid = 1'b1;
        nxt_w = w;
        nxt_a = a;
        nxt_d = d;
    endtask

    // Entered at a falling edge with the request on the inputs; leaves in ENABLE
    task automatic run(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic prev);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
        if (nxt_valid) begin
            put(nxt_w, nxt_a, nxt_d);
        end else begin
            req_valid = 1'b0;
        end
        nxt_valid = 1'b0;
        cmp_bit(rsp_valid, prev);
        cmp_word(32'(psel), sel_of(a));
        cmp_bit(penable, 1'b0);
        cmp_bit(req_ready, 1'b0);
        cmp_word(paddr, a);
        cmp_bit(pwrite, w);
        if (w) cmp_word(pwdata, d);
        @(negedge clock);
        cmp_bit(penable, 1'b1);
        cmp_word(32'(psel), sel_of(a));
        cmp_word(paddr, a);
        cmp_bit(pwrite, w);
        cmp_bit(req_ready, 1'b1);
        if (w) cmp_word(pwdata, d);
    endtask

    task automatic done(input logic w, input logic [31:0] exp);
        @(negedge clock);
        cmp_bit(rsp_valid, 1'b1);
        cmp_bit(penable, 1'b0);
        cmp_word(32'(psel), 32'h0000_0000);
        if (!w) cmp_word(rsp_rdata, exp);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_each_slave();
        logic [31:0] a;
        for (int s = 0; s < NSEL; s++) begin
            a = 32'(s) << `APBX_SEL_LSB;
            @(negedge clock);
            put(1'b1, a, 32'hA5A5_0000 | 32'(s));
            run(1'b1, a, 32'hA5A5_0000 | 32'(s), 1'b0);
            done(1'b1, 32'h0000_0000);
            put(1'b0, a, 32'hFFFF_FFFF);
            run(1'b0, a, 32'hFFFF_FFFF, 1'b0);
            done(1'b0, 32'hA5A5_0000 | 32'(s));
        end
    endtask

    // Same-slave writes, then reads with no idle between any of them
    task automatic t_back_to_back();
        @(negedge clock);
        put(1'b1, 32'h0000_1004, 32'h1111_2222);
        set_next(1'b1, 32'h0000_1008, 32'h3333_4444);
        run(1'b1, 32'h0000_1004, 32'h1111_2222, 1'b0);
        set_next(1'b0, 32'h0000_2000, 32'h0000_0000);
        run(1'b1, 32'h0000_1008, 32'h3333_4444, 1'b1);
        set_next(1'b0, 32'h0000_1004, 32'h0000_0000);
        run(1'b0, 32'h0000_2000, 32'h0000_0000, 1'b1);
        run(1'b0, 32'h0000_1004, 32'h0000_0000, 1'b1);
        done(1'b0, 32'h1111_2222);
    endtask

    task automatic t_idle_hold();
        @(negedge clock);
        put(1'b1, 32'h0000_300C, 32'h0BAD_F00D);
        run(1'b1, 32'h0000_300C, 32'h0BAD_F00D, 1'b0);
        done(1'b1, 32'h0000_0000);
        repeat (3) @(negedge clock);
        cmp_word(paddr, 32'h0000_300C);
        cmp_bit(pwrite, 1'b1);
        cmp_bit(penable, 1'b0);
        cmp_word(32'(psel), 32'h0000_0000);
        cmp_bit(rsp_valid, 1'b0);
    endtask

    // Reset lands in SETUP; the bus must drop at once and stay idle
    task automatic t_mid_reset();
        @(negedge clock);
        put(1'b0, 32'h0000_2004, 32'h0000_0000);
        @(negedge clock);
        arst_n = 1'b0;
        req_valid = 1'b0;
        #1;
        cmp_word(32'(psel), 32'h0000_0000);
        cmp_bit(penable, 1'b0);
        cmp_bit(req_ready, 1'b1);
        @(negedge clock);
        arst_n = 1'b1;
        @(negedge clock);
        cmp_bit(penable, 1'b0);
        cmp_word(paddr, 32'h0000_0000);
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        repeat (4) @(negedge clock);
        arst_n = 1'b1;
        cmp_bit(req_ready, 1'b1);
        cmp_bit(penable, 1'b0);
        cmp_word(32'(psel), 32'h0000_0000);
        cmp_bit(rsp_valid, 1'b0);
        t_each_slave();
        t_back_to_back();
        t_idle_hold();
        t_mid_reset();
        stop_test();
    end

    // About 53 cycles of tests; a generous margin before calling it a hang
    initial begin
        #(2_000 * 100);
        n_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
